// *** src/fbu_uart.sv ***
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module fbu_uart import fbu_pkg::*; #(
    parameter int FIFO_DEPTH = 4,
    parameter int RX_PINS = 4,
    parameter int TX_PINS = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins
    input wire logic [RX_PINS-1:0] pin_rx,
    output logic [TX_PINS-1:0] pin_tx,
    output logic [TX_PINS-1:0] pin_tx_oe_n,
    // Interrupt
    output logic irq
);
    initial begin
        if (FIFO_DEPTH != 4 || RX_PINS != 4 || TX_PINS != 3) $error("Unsupported geometry");
    end
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int MUXW = 3 * (RX_PINS + TX_PINS);

    // Software state
    fbu_cfg_t cfg, next_cfg;
    logic [15:0] baud, next_baud;
    logic [IRQ_W-1:0] ist, next_ist, imask, next_imask;
    logic [MUXW-1:0] mux, next_mux;
    logic [31:0] next_dat;
    logic next_ack, next_irq;
    logic rx_pop, tx_push;
    logic [7:0] rxf_data;
    logic rxf_valid, txf_ready;
    logic [LW-1:0] rx_level, tx_level;
    logic [IRQ_W-1:0] ev;
    logic wr_acc, rd_acc;
    always_comb begin
        wr_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
        rd_acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    end

    // Register decode; ack one cycle after strobe, unmapped reads zero
    always_comb begin
        next_cfg = cfg;
        next_baud = baud;
        next_imask = imask;
        next_mux = mux;
        next_dat = '0;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        rx_pop = 1'b0;
        tx_push = 1'b0;
        next_ist = ist | ev; // Set wins over clear
        if (wr_acc) begin
            unique case (wb_adr_i)
                ADDR_CTRL: if (wb_sel_i[0]) next_cfg = fbu_cfg_t'(wb_dat_i[6:0]);
                ADDR_BAUD: begin
                    if (wb_sel_i[0]) next_baud[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) next_baud[15:8] = wb_dat_i[15:8];
                end
                ADDR_DATA: tx_push = wb_sel_i[0];
                ADDR_IRQ: if (wb_sel_i[0]) next_ist = (ist & ~wb_dat_i[IRQ_W-1:0]) | ev;
                ADDR_MASK: if (wb_sel_i[0]) next_imask = wb_dat_i[IRQ_W-1:0];
                ADDR_MUX: if (&wb_sel_i[2:0]) next_mux = wb_dat_i[MUXW-1:0];
                default: ;
            endcase
        end
        if (rd_acc) begin
            unique case (wb_adr_i)
                ADDR_CTRL: next_dat = {25'h000_0000, cfg};
                ADDR_BAUD: next_dat = {16'h0000, baud};
                ADDR_DATA: begin
                    next_dat = {24'h0000_00, rxf_data};
                    rx_pop = rxf_valid;
                end
                // Receive level at [4:2], transmit full at [1]
                ADDR_STAT: next_dat = {27'h000_0000, rx_level, !txf_ready, 1'b0};
                ADDR_IRQ: next_dat = {27'h000_0000, ist};
                ADDR_MASK: next_dat = {27'h000_0000, imask};
                ADDR_MUX: next_dat = {11'h000, mux};
                default: next_dat = '0;
            endcase
        end
        next_irq = |(next_ist & next_imask);
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= '0;
            baud <= BAUD_RESET;
            ist <= '0;
            imask <= '0;
            mux <= '0;
            wb_dat_o <= '0;
            wb_ack_o <= 1'b0;
            irq <= 1'b0;
        end else begin
            cfg <= next_cfg;
            baud <= next_baud;
            ist <= next_ist;
            imask <= next_imask;
            mux <= next_mux;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
            irq <= next_irq;
        end
    end

    // FIFOs, four by eight each way
    logic [7:0] txf_data;
    logic txf_valid, tx_take;
    fbu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .in_valid(tx_push), .in_ready(txf_ready), .in_data(wb_dat_i[7:0]),
        .out_valid(txf_valid), .out_ready(tx_take), .out_data(txf_data), .level(tx_level));
    logic rx_put, rxf_ready;
    logic [7:0] rx_char;
    fbu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxf (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .in_valid(rx_put), .in_ready(rxf_ready), .in_data(rx_char),
        .out_valid(rxf_valid), .out_ready(rx_pop), .out_data(rxf_data), .level(rx_level));

    // Engine clock ticks: 10 MHz base, divided by 1, 2, 4 or 8
    logic [5:0] pre, next_pre;
    logic eng_tick;
    always_comb begin
        next_pre = pre + 6'h01;
        if (next_pre == 6'((ENG_BASE_DIV << cfg.clk_sel))) next_pre = '0;
        eng_tick = pre == '0;
    end
    // Fractional divider counts in eighths; one bit lasts baud/8 engine ticks
    logic [15:0] acc, next_acc;
    logic os_tick;
    always_comb begin
        // Accumulating 8 per engine tick against baud keeps the remainder spread
        next_acc = acc;
        os_tick = 1'b0;
        if (eng_tick) begin
            if (acc + 16'h0008 >= baud) begin
                next_acc = 16'(acc + 16'h0008 - baud);
                os_tick = 1'b1;
            end else begin
                next_acc = acc + 16'h0008;
            end
        end
    end
    // Transmit divider state; the receiver keeps its own phase to centre on a start edge
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pre <= '0;
            acc <= '0;
        end else begin
            pre <= next_pre;
            acc <= next_acc;
        end
    end

    // Pin multiplexing: a pin carries the serial line only at mux value 3
    logic rx_raw, rx_sync, rx_s1, tx_line;
    always_comb begin
        rx_raw = 1'b1;
        for (int i = 0; i < RX_PINS; i++) begin
            if (mux[3*i +: 3] == MUX_UART) rx_raw = pin_rx[i];
        end
    end

    // Transmitter; one bit lasts one divider period, os_tick
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fbu_txs_t;
    fbu_txs_t txs, next_txs;
    logic [7:0] tsh, next_tsh;
    logic [2:0] tcnt, next_tcnt;
    logic tpar, next_tpar, next_tx_line;
    always_comb begin
        next_txs = txs;
        next_tsh = tsh;
        next_tcnt = tcnt;
        next_tpar = tpar;
        next_tx_line = tx_line;
        tx_take = 1'b0;
        if (os_tick) begin
            unique case (txs)
                TX_IDLE: begin
                    next_tx_line = 1'b1;
                    if (txf_valid) begin
                        tx_take = 1'b1;
                        next_tsh = txf_data;
                        next_tpar = fbu_par_bit(txf_data, cfg.eight_bits, cfg.parity);
                        next_tx_line = 1'b0;
                        next_txs = TX_START;
                    end
                end
                TX_START: begin
                    next_tx_line = tsh[0];
                    next_tcnt = cfg.eight_bits ? 3'h7 : 3'h6;
                    next_txs = TX_DATA;
                end
                TX_DATA: begin
                    next_tsh = tsh >> 1;
                    if (tcnt == '0) begin
                        next_txs = cfg.parity == PAR_NONE ? TX_STOP : TX_PAR;
                        next_tx_line = cfg.parity == PAR_NONE ? 1'b1 : tpar;
                        next_tcnt = {2'b00, cfg.two_stop};
                    end else begin
                        next_tcnt = tcnt - 3'h1;
                        next_tx_line = tsh[1];
                    end
                end
                TX_PAR: begin
                    next_tx_line = 1'b1;
                    next_txs = TX_STOP;
                end
                TX_STOP: begin
                    if (tcnt == '0) next_txs = TX_IDLE;
                    else next_tcnt = tcnt - 3'h1;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            txs <= TX_IDLE;
            tsh <= '0;
            tcnt <= '0;
            tpar <= 1'b0;
            tx_line <= 1'b1;
        end else begin
            txs <= next_txs;
            tsh <= next_tsh;
            tcnt <= next_tcnt;
            tpar <= next_tpar;
            tx_line <= next_tx_line;
        end
    end
    // Pins: drive only where mux selects the serial function, active-low enable
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_tx <= '1;
            pin_tx_oe_n <= '1;
        end else begin
            for (int j = 0; j < TX_PINS; j++) begin
                pin_tx[j] <= next_tx_line;
                pin_tx_oe_n[j] <= next_mux[3*(RX_PINS+j) +: 3] != MUX_UART;
            end
        end
    end

    // Receiver: start edge then sample each bit at mid-period
    typedef enum {RX_IDLE, RX_BITS} fbu_rxs_t;
    fbu_rxs_t rxs, next_rxs;
    logic [3:0] rbit, next_rbit, rtot;
    logic [15:0] racc, next_racc;
    logic [11:0] rsh, next_rsh;
    logic rsamp, par_bad, frm_bad;
    always_comb begin
        rtot = 4'(cfg.eight_bits ? 9 : 8) + 4'(cfg.parity != PAR_NONE) + 4'(cfg.two_stop);
        next_rxs = rxs;
        next_rbit = rbit;
        next_racc = racc;
        next_rsh = rsh;
        rsamp = 1'b0;
        if (rxs == RX_IDLE) begin
            // Start one half period behind the edge to land mid-bit
            next_racc = 16'(baud >> 1);
            next_rbit = '0;
            if (!rx_sync) next_rxs = RX_BITS;
        end else if (eng_tick) begin
            if (racc + 16'h0008 >= baud) begin
                next_racc = 16'(racc + 16'h0008 - baud);
                rsamp = 1'b1;
            end else begin
                next_racc = racc + 16'h0008;
            end
        end
        if (rsamp) begin
            next_rsh = {rx_sync, rsh[11:1]};
            next_rbit = rbit + 4'h1;
            if (rbit == '0 && rx_sync) next_rxs = RX_IDLE; // False start
            if (rbit == rtot) next_rxs = RX_IDLE;
        end
    end
    // Align frame: rsh holds start..last stop, shifted right by 12-(rtot+1); twelve bits fit the longest frame
    logic [11:0] fr;
    logic [7:0] rdat;
    always_comb begin
        fr = next_rsh >> (4'd11 - rtot);
        rdat = cfg.eight_bits ? fr[8:1] : {1'b0, fr[7:1]};
        par_bad = cfg.parity != PAR_NONE &&
            fr[cfg.eight_bits ? 9 : 8] != fbu_par_bit(rdat, cfg.eight_bits, cfg.parity);
        frm_bad = !fr[rtot] || (cfg.two_stop && !fr[rtot-4'h1]);
        rx_put = rsamp && rbit == rtot && rxs == RX_BITS;
        rx_char = rdat;
        ev = '0;
        ev[IRQ_RX_AVAIL] = rx_put && rxf_ready;
        ev[IRQ_TX_EMPTY] = tx_take && tx_level == LW'(1);
        ev[IRQ_PARITY] = rx_put && par_bad;
        ev[IRQ_FRAME] = rx_put && frm_bad;
        ev[IRQ_OVERRUN] = rx_put && !rxf_ready;
    end
    // Receive line synchroniser and state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_s1 <= 1'b1;
            rx_sync <= 1'b1;
            rxs <= RX_IDLE;
            rbit <= '0;
            racc <= '0;
            rsh <= '0;
        end else begin
            rx_s1 <= rx_raw;
            rx_sync <= rx_s1;
            rxs <= next_rxs;
            rbit <= next_rbit;
            racc <= next_racc;
            rsh <= next_rsh;
        end
    end

    // Checks
    mux_reset_a: assert property (@(posedge clk_sys) $fell(sys_rst) |-> mux == '0 && pin_tx_oe_n == '1)
        else $error("mux not cleared by reset");
    tx_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (txs == TX_IDLE && os_tick && txf_valid) |=> !tx_line)
        else $error("start bit not low");
    tx_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (txs == TX_IDLE && $past(txs) == TX_IDLE) |-> tx_line)
        else $error("idle line not high");
    ovr_a: assert property (@(posedge clk_sys) disable iff (sys_rst) (rx_put && !rxf_ready) |=> ist[IRQ_OVERRUN])
        else $error("overrun lost");
    irq_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        irq == |(ist & imask))
        else $error("irq mismatch");
    rx_cnt_a: assert property (@(posedge clk_sys) disable iff (sys_rst) rx_level <= LW'(FIFO_DEPTH))
        else $error("rx count overflow");
    par_kind_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (txs == TX_PAR && cfg.parity == PAR_MARK) |-> tx_line)
        else $error("mark parity not high");
    stop_hi_a: assert property (@(posedge clk_sys) disable iff (sys_rst) txs == TX_STOP |-> tx_line)
        else $error("stop bit not high");
    ack_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst) wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule

// *** src/fbu_pkg.sv ***
package fbu_pkg;
    localparam int SYS_CLK_HZ = 40000000;
    localparam int ENG_BASE_HZ = 10000000;
    // Engine base tick every this many system clocks
    localparam int ENG_BASE_DIV = SYS_CLK_HZ / ENG_BASE_HZ;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BAUD = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_MUX = 8'h18;
    localparam logic [2:0] MUX_UART = 3'h3;
    localparam logic [2:0] MUX_GPIO = 3'h0;
    localparam logic [15:0] BAUD_RESET = 16'h0040;
    localparam int IRQ_RX_AVAIL = 0;
    localparam int IRQ_TX_EMPTY = 1;
    localparam int IRQ_PARITY = 2;
    localparam int IRQ_FRAME = 3;
    localparam int IRQ_OVERRUN = 4;
    localparam int IRQ_W = 5;
    typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} fbu_par_t;
    typedef struct packed {
        logic [1:0] clk_sel;
        logic eight_bits;
        fbu_par_t parity;
        logic two_stop;
    } fbu_cfg_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic par_err;
        logic frm_err;
    } fbu_rxch_t;
    function automatic logic fbu_par_bit(input logic [7:0] d, input logic eight, input fbu_par_t p);
        logic x;
        x = eight ? ^d : ^d[6:0];
        unique case (p)
            PAR_ODD: fbu_par_bit = ~x;
            PAR_EVEN: fbu_par_bit = x;
            PAR_MARK: fbu_par_bit = 1'b1;
            default: fbu_par_bit = 1'b0;
        endcase
    endfunction
endpackage

// *** src/fbu_fifo.sv ***
`timescale 1ns/10ps
module fbu_fifo import fbu_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic do_wr, do_rd;
    // Pointer arithmetic; extra bit tells full from empty
    always_comb begin
        level = wr_ptr - rd_ptr;
        in_ready = level != (AW+1)'(DEPTH);
        out_valid = level != '0;
        out_data = mem[rd_ptr[AW-1:0]];
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        next_wr_ptr = wr_ptr + (AW+1)'(do_wr);
        next_rd_ptr = rd_ptr + (AW+1)'(do_rd);
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
    // Storage has no reset; contents matter only once written
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// *** verification/fbu_peer.sv ***
`timescale 1ns/10ps
module fbu_peer (
    // Clock
    input wire logic clk_sys,
    // Serial lines, terminal side
    input wire logic line_in,
    output logic [3:0] line_out
);
    // Lines idle high between frames, as a terminal's marking state
    initial begin
        line_out = 4'hF;
    end

    // Sends len bits, first bit first, each held per clocks, then idles high
    task automatic send(input int pin, input logic [11:0] bits, input int len, input int per);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_sys);
            line_out[pin] <= bits[i];
            repeat (per - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        line_out[pin] <= 1'b1;
    endtask

    // Waits for a start edge, then samples each bit near its middle
    task automatic recv(input int len, input int per, output logic [11:0] bits);
        int w;
        w = 0;
        // Bits past the frame read as idle high, as the expected frame does
        bits = '1;
        while (line_in !== 1'b0 && w < 6000) begin
            @(posedge clk_sys);
            w++;
        end
        repeat (per / 2) @(posedge clk_sys);
        for (int i = 0; i < len; i++) begin
            bits[i] = line_in;
            repeat (per) @(posedge clk_sys);
        end
    endtask

    // Length in clocks of the next low stretch; both waits are bounded
    task automatic low_time(output int n);
        int w;
        w = 0;
        n = 0;
        while (line_in !== 1'b0 && w < 6000) begin
            @(posedge clk_sys);
            w++;
        end
        while (line_in === 1'b0 && n < 6000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
endmodule

// *** verification/fbu_uart_test.sv ***
`timescale 1ns/10ps
module fbu_uart_test import fbu_pkg::*;;
    logic clk_sys, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack_o, irq;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel, pin_rx;
    logic [31:0] wb_dat, wb_dat_o, q;
    logic [2:0] pin_tx, pin_tx_oe_n;
    logic [11:0] got, exp;
    int bad_count, n_compared, cycles, len, t;

    fbu_uart fbu_uart_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_rx(pin_rx), .pin_tx(pin_tx), .pin_tx_oe_n(pin_tx_oe_n), .irq(irq));
    fbu_peer fbu_peer_i (.clk_sys(clk_sys), .line_in(pin_tx[1]), .line_out(pin_rx));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many clocks
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    // One classic cycle; the ack is awaited, never assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 50) chk("ack", 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0000_0000, r);
        chk(name, e, r);
    endtask

    // Expected line bits, first on the wire at index 0; parity worked out here
    function automatic logic [11:0] frame(input logic [7:0] d, input logic e8, input logic [2:0] par,
        input logic two, output int n);
        logic p;
        p = e8 ? ^d : ^d[6:0];
        frame = 12'hFFF;
        frame[0] = 1'b0;
        n = e8 ? 9 : 8;
        for (int i = 1; i < n; i++) frame[i] = d[i-1];
        if (par != 3'h0) begin
            frame[n] = (par == 3'h1) ? ~p : (par == 3'h2) ? p : (par == 3'h3);
            n++;
        end
        n += two ? 2 : 1;
    endfunction

    // Format table: eight bits, parity kind, two stop bits
    logic [4:0] fmt [5] = '{5'b1_000_0, 5'b0_001_1, 5'b1_010_0, 5'b0_011_1, 5'b1_100_0};
    // Timing table: clock select, divider, low clocks for nine bit times
    int tsel [5] = '{0, 1, 2, 3, 0};
    logic [15:0] tdiv [5] = '{16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0044};
    int tlow [5] = '{288, 576, 1152, 2304, 306};

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        wb_sel = 4'hF;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk("oe_n", 32'h0000_0007, 32'(pin_tx_oe_n));
        chk("tx idle", 32'h0000_0007, 32'(pin_tx));
        rchk("mux", ADDR_MUX, 32'h0000_0000);
        rchk("baud", ADDR_BAUD, 32'h0000_0040);
        rchk("unmapped", 8'h1C, 32'h0000_0000);
        // Receive on rx pin 2, transmit on tx pin 1
        wb(1'b1, ADDR_MUX, 32'h0001_80C0, q);
        repeat (2) @(posedge clk_sys);
        chk("oe_n", 32'h0000_0005, 32'(pin_tx_oe_n));
        // Transmit one character in every format
        for (int i = 0; i < 5; i++) begin
            exp = frame(8'h45 + 8'(i * 27), fmt[i][4], fmt[i][3:1], fmt[i][0], len);
            wb(1'b1, ADDR_CTRL, 32'({2'b00, fmt[i]}), q);
            fork
                fbu_peer_i.recv(len, 32, got);
                wb(1'b1, ADDR_DATA, 32'(8'h45 + 8'(i * 27)), q);
            join
            chk("tx frame", 32'(exp), 32'(got));
        end
        // Five characters into a four-deep FIFO, the fourth with bad parity
        wb(1'b1, ADDR_CTRL, 32'h0000_0014, q);
        for (int i = 1; i < 6; i++) begin
            exp = frame(8'(i * 17), 1'b1, 3'h2, 1'b0, len);
            fbu_peer_i.send(2, (i == 4) ? exp ^ 12'h200 : exp, len, 32);
        end
        repeat (4) @(posedge clk_sys);
        rchk("rx level", ADDR_STAT, 32'h0000_0010);
        rchk("status", ADDR_IRQ, 32'h0000_0017);
        chk("irq", 32'h0000_0000, 32'(irq));
        wb(1'b1, ADDR_MASK, 32'h0000_0004, q);
        repeat (2) @(posedge clk_sys);
        chk("irq", 32'h0000_0001, 32'(irq));
        wb(1'b1, ADDR_IRQ, 32'h0000_0004, q);
        repeat (2) @(posedge clk_sys);
        chk("irq", 32'h0000_0000, 32'(irq));
        rchk("status", ADDR_IRQ, 32'h0000_0013);
        for (int i = 1; i < 5; i++) rchk("rx data", ADDR_DATA, 32'(8'(i * 17)));
        rchk("rx level", ADDR_STAT, 32'h0000_0000);
        // Bit time against clock select and fractional divider, all 8.0 or more
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, ADDR_BAUD, 32'(tdiv[i]), q);
            wb(1'b1, ADDR_CTRL, 32'({tsel[i][1:0], 5'b1_000_0}), q);
            fork
                fbu_peer_i.low_time(t);
                wb(1'b1, ADDR_DATA, 32'h0000_0000, q);
            join
            chk("low clocks", 32'(tlow[i]), 32'((t > tlow[i] - 8 && t < tlow[i] + 8) ? tlow[i] : t));
            repeat (tlow[i] / 4) @(posedge clk_sys);
        end
        conclude();
    end
endmodule
